// ### rtl/crt_raster_map.svh
// register indices, field positions, reset values and timing counts of the raster timing block
`ifndef CRT_RASTER_MAP_SVH
`define CRT_RASTER_MAP_SVH
`define CRT_IDX_HTOTAL 5'h00
`define CRT_IDX_HDISP 5'h01
`define CRT_IDX_HSYNC_POS 5'h02
`define CRT_IDX_SYNC_WIDTHS 5'h03
`define CRT_IDX_VTOTAL 5'h04
`define CRT_IDX_VADJUST 5'h05
`define CRT_IDX_VDISP 5'h06
`define CRT_IDX_VSYNC_ROW 5'h07
`define CRT_IDX_MODE 5'h08
`define CRT_IDX_SCAN 5'h09
`define CRT_IDX_CUR_START 5'h0a
`define CRT_IDX_CUR_END 5'h0b
`define CRT_IDX_START_HI 5'h0c
`define CRT_IDX_START_LO 5'h0d
`define CRT_IDX_CUR_HI 5'h0e
`define CRT_IDX_CUR_LO 5'h0f
`define CRT_IDX_PEN_HI 5'h10
`define CRT_IDX_PEN_LO 5'h11
`define CRT_IDX_UPD_HI 5'h12
`define CRT_IDX_UPD_LO 5'h13
`define CRT_IDX_DUMMY 5'h1f
`define CRT_HSW_LSB 0
`define CRT_HSW_MSB 3
`define CRT_VSW_LSB 4
`define CRT_VSW_MSB 7
`define CRT_CMODE_LSB 5
`define CRT_CMODE_MSB 6
`define CRT_MODE_RC_BIT 2
`define CRT_MODE_DE_DLY_BIT 4
`define CRT_MODE_CUR_DLY_BIT 5
`define CRT_STAT_UPD_BIT 7
`define CRT_STAT_PEN_BIT 6
`define CRT_STAT_VBLANK_BIT 5
`define CRT_VSYNC_ZERO_LINES 5'h10
`define CRT_RST_BYTE 8'h00
`define CRT_RST_ADDR 14'h0000
`endif

// ### rtl/crt_pkg.sv
// shared types of the raster timing block
package crt_pkg;
	typedef enum logic [1:0]
	{
		crt_v_rows = 2'b01,
		crt_v_adjust = 2'b10
	} crt_vstate_t;
	typedef enum logic [1:0]
	{
		crt_cur_steady = 2'b00,
		crt_cur_off = 2'b01,
		crt_cur_blink16 = 2'b10,
		crt_cur_blink32 = 2'b11
	} crt_cur_mode_t;
endpackage

// ### rtl/crt_cur_if.sv
// carrier between the raster generator and the cursor unit
`timescale 1ns/1ns
interface crt_cur_if;
	logic tick;
	logic run;
	logic frame_tick;
	logic [13:0] ma;
	logic [4:0] ra;
	logic [13:0] cur_pos;
	logic [4:0] cur_start;
	logic [4:0] cur_end;
	crt_pkg::crt_cur_mode_t cur_mode;
	logic delay;
	logic cursor;
	modport raster
	(
		output tick, run, frame_tick, ma, ra, cur_pos, cur_start, cur_end, cur_mode, delay,
		input cursor
	);
	modport curs
	(
		input tick, run, frame_tick, ma, ra, cur_pos, cur_start, cur_end, cur_mode, delay,
		output cursor
	);
endinterface

// ### rtl/crt_cursor.sv
// cursor compare, blink timing and optional one-character delay
`timescale 1ns/1ns
module crt_cursor
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// raster side
	crt_cur_if.curs cif
);
	logic [4:0] frame_cnt_reg;
	logic stage_reg;
	logic cursor_reg;
	logic blink_on;
	logic hit;
	always_comb
	begin
		case (cif.cur_mode)
			crt_pkg::crt_cur_steady: blink_on = 1'b1;
			crt_pkg::crt_cur_off: blink_on = 1'b0;
			crt_pkg::crt_cur_blink16: blink_on = ~frame_cnt_reg[3];
			crt_pkg::crt_cur_blink32: blink_on = ~frame_cnt_reg[4];
			default: blink_on = 1'b0;
		endcase
	end
	// an empty window (start above end) simply never shows a cursor
	assign hit = blink_on & (cif.ma == cif.cur_pos) & (cif.ra >= cif.cur_start)
		& (cif.ra <= cif.cur_end);
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			frame_cnt_reg <= 5'h00;
			stage_reg <= 1'b0;
			cursor_reg <= 1'b0;
		end
		else if (!cif.run)
		begin
			frame_cnt_reg <= 5'h00;
			stage_reg <= 1'b0;
			cursor_reg <= 1'b0;
		end
		else if (cif.tick)
		begin
			if (cif.frame_tick)
				frame_cnt_reg <= frame_cnt_reg + 5'h01;
			stage_reg <= hit;
			cursor_reg <= cif.delay ? stage_reg : hit;
		end
	end
	assign cif.cursor = cursor_reg;
endmodule

// ### rtl/crt_raster_timing_regs.sv
// raster timing, refresh addressing, light pen and processor register port
`timescale 1ns/1ns
`include "crt_raster_map.svh"
module crt_raster_timing_regs
(
	// system clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// processor port pins
	input wire logic bus_enable,
	input wire logic read_not_write,
	input wire logic chip_select_n,
	input wire logic register_select_pin,
	input wire logic [7:0] data_bus_in,
	output logic [7:0] data_bus_out,
	output logic data_bus_oe,
	// video timing pins
	input wire logic character_clock,
	input wire logic counter_reset_n,
	input wire logic light_pen_strobe,
	output logic hsync,
	output logic vsync,
	output logic display_enable,
	output logic cursor,
	output logic [13:0] refresh_address,
	output logic [4:0] raster_row_address
);
	function automatic logic [13:0] upd_inc(input logic rc, input logic [13:0] a);
		upd_inc = rc ? {a[13:8], a[7:0] + 8'h01} : a + 14'h0001;
	endfunction
	function automatic logic [13:0] ma_calc(input logic rc, input logic [13:0] base,
		input logic [13:0] start, input logic [6:0] row, input logic [7:0] col);
		ma_calc = rc ? {start[13:8] + row[5:0], start[7:0] + col} : base + {6'h00, col};
	endfunction

	// all pins cross from outside through two flops
	logic [14:0] sync1_reg;
	logic [14:0] sync2_reg;
	logic [14:0] sync3_reg;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_reg <= 15'h0000;
			sync2_reg <= 15'h0000;
			sync3_reg <= 15'h0000;
		end
		else
		begin
			sync1_reg <= {character_clock, light_pen_strobe, counter_reset_n, bus_enable,
				chip_select_n, register_select_pin, read_not_write, data_bus_in};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end
	wire character_clock_rise = sync2_reg[14] & ~sync3_reg[14];
	wire character_clock_fall = ~sync2_reg[14] & sync3_reg[14];
	wire pen_rise = sync2_reg[13] & ~sync3_reg[13];
	wire run = sync2_reg[12];
	wire e_fall = ~sync2_reg[11] & sync3_reg[11];
	wire cs_n_s = sync2_reg[10];
	wire rs_s = sync2_reg[9];
	wire rw_s = sync2_reg[8];
	wire [7:0] db_s = sync2_reg[7:0];

	// register storage, kept across counter reset
	logic [4:0] ptr_reg;
	logic [7:0] horizontal_total_reg;
	logic [7:0] hdisp_reg;
	logic [7:0] hsync_pos_reg;
	logic [7:0] sync_widths_reg;
	logic [6:0] vertical_total_reg;
	logic [4:0] vertical_adjust_reg;
	logic [6:0] vertical_displayed_reg;
	logic [6:0] vertical_sync_row_reg;
	logic [7:0] mode_control_reg;
	logic [4:0] scan_line_count_reg;
	logic [6:0] cursor_start_reg;
	logic [4:0] cursor_end_reg;
	logic [13:0] display_start_reg;
	logic [13:0] cursor_position_reg;
	logic [13:0] light_pen_reg;
	logic [13:0] update_address_reg;
	logic upd_ready_reg;
	logic pen_full_reg;
	logic pen_pend_reg;

	wire wr = e_fall & ~cs_n_s & ~rw_s;
	wire rd = e_fall & ~cs_n_s & rw_s;
	wire wr_ptr = wr & ~rs_s;
	wire wr_data = wr & rs_s;
	wire rd_data = rd & rs_s;
	wire dummy_hit = (wr_data | rd_data) & (ptr_reg == `CRT_IDX_DUMMY);
	wire pen_read = rd_data & ((ptr_reg == `CRT_IDX_PEN_HI) | (ptr_reg == `CRT_IDX_PEN_LO));
	wire upd_write = wr_data & ((ptr_reg == `CRT_IDX_UPD_HI) | (ptr_reg == `CRT_IDX_UPD_LO));
	wire rc_mode = mode_control_reg[`CRT_MODE_RC_BIT];

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ptr_reg <= 5'h00;
			horizontal_total_reg <= `CRT_RST_BYTE;
			hdisp_reg <= `CRT_RST_BYTE;
			hsync_pos_reg <= `CRT_RST_BYTE;
			sync_widths_reg <= `CRT_RST_BYTE;
			vertical_total_reg <= 7'h00;
			vertical_adjust_reg <= 5'h00;
			vertical_displayed_reg <= 7'h00;
			vertical_sync_row_reg <= 7'h00;
			mode_control_reg <= `CRT_RST_BYTE;
			scan_line_count_reg <= 5'h00;
			cursor_start_reg <= 7'h00;
			cursor_end_reg <= 5'h00;
			display_start_reg <= `CRT_RST_ADDR;
			cursor_position_reg <= `CRT_RST_ADDR;
		end
		else if (wr_ptr)
			ptr_reg <= db_s[4:0];
		else if (wr_data)
		begin
			case (ptr_reg)
				`CRT_IDX_HTOTAL: horizontal_total_reg <= db_s;
				`CRT_IDX_HDISP: hdisp_reg <= db_s;
				`CRT_IDX_HSYNC_POS: hsync_pos_reg <= db_s;
				`CRT_IDX_SYNC_WIDTHS: sync_widths_reg <= db_s;
				`CRT_IDX_VTOTAL: vertical_total_reg <= db_s[6:0];
				`CRT_IDX_VADJUST: vertical_adjust_reg <= db_s[4:0];
				`CRT_IDX_VDISP: vertical_displayed_reg <= db_s[6:0];
				`CRT_IDX_VSYNC_ROW: vertical_sync_row_reg <= db_s[6:0];
				`CRT_IDX_MODE: mode_control_reg <= db_s;
				`CRT_IDX_SCAN: scan_line_count_reg <= db_s[4:0];
				`CRT_IDX_CUR_START: cursor_start_reg <= db_s[6:0];
				`CRT_IDX_CUR_END: cursor_end_reg <= db_s[4:0];
				`CRT_IDX_START_HI: display_start_reg[13:8] <= db_s[5:0];
				`CRT_IDX_START_LO: display_start_reg[7:0] <= db_s;
				`CRT_IDX_CUR_HI: cursor_position_reg[13:8] <= db_s[5:0];
				`CRT_IDX_CUR_LO: cursor_position_reg[7:0] <= db_s;
				default: ptr_reg <= ptr_reg;
			endcase
		end
	end

	// update address: written by software, stepped by dummy accesses
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			update_address_reg <= `CRT_RST_ADDR;
		else if (upd_write & (ptr_reg == `CRT_IDX_UPD_HI))
			update_address_reg[13:8] <= db_s[5:0];
		else if (upd_write)
			update_address_reg[7:0] <= db_s;
		else if (dummy_hit)
			update_address_reg <= upd_inc(rc_mode, update_address_reg);
	end

	// status flags: a set in the same cycle as its clear wins
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			upd_ready_reg <= 1'b0;
			pen_full_reg <= 1'b0;
			pen_pend_reg <= 1'b0;
			light_pen_reg <= `CRT_RST_ADDR;
		end
		else
		begin
			upd_ready_reg <= dummy_hit | (upd_ready_reg & ~upd_write);
			if (pen_pend_reg & character_clock_fall)
			begin
				light_pen_reg <= refresh_address;
				pen_full_reg <= 1'b1;
			end
			else if (pen_read)
				pen_full_reg <= 1'b0;
			if (pen_rise)
				pen_pend_reg <= 1'b1;
			else if (character_clock_fall)
				pen_pend_reg <= 1'b0;
		end
	end

	// raster counters, advanced on the rising character clock, row and line counts only at a line end
	crt_pkg::crt_vstate_t vstate_reg;
	logic [7:0] h_cnt_reg;
	logic [6:0] row_cnt_reg;
	logic [4:0] line_cnt_reg;
	logic [3:0] hs_cnt_reg;
	logic [4:0] vs_cnt_reg;
	logic [13:0] row_base_reg;
	logic de_stage_reg;

	wire in_rows = (vstate_reg == crt_pkg::crt_v_rows);
	wire h_end = (h_cnt_reg == horizontal_total_reg);
	wire last_line = (line_cnt_reg == scan_line_count_reg);
	wire last_row = (row_cnt_reg == vertical_total_reg);
	wire adj_done = (line_cnt_reg == vertical_adjust_reg - 5'h01);
	wire frame_end = h_end & ((in_rows & last_line & last_row & (vertical_adjust_reg == 5'h00))
		| (~in_rows & adj_done));
	wire line_tick = character_clock_rise & h_end;
	wire [3:0] hsw = sync_widths_reg[`CRT_HSW_MSB:`CRT_HSW_LSB];
	wire [3:0] vsw = sync_widths_reg[`CRT_VSW_MSB:`CRT_VSW_LSB];
	wire [4:0] vs_len = (vsw == 4'h0) ? `CRT_VSYNC_ZERO_LINES : {1'b0, vsw};
	wire hs_start = (h_cnt_reg == hsync_pos_reg);
	wire vs_start = (frame_end & (vertical_sync_row_reg == 7'h00)) | (~frame_end & in_rows
		& h_end & last_line & (row_cnt_reg + 7'h01 == vertical_sync_row_reg));
	wire [3:0] hs_next = hs_start ? hsw : ((hs_cnt_reg != 4'h0) ? hs_cnt_reg - 4'h1 : 4'h0);
	wire [4:0] vs_dec = (vs_cnt_reg != 5'h00) ? vs_cnt_reg - 5'h01 : 5'h00;
	wire [4:0] vs_next = (h_end & vs_start) ? vs_len : (h_end ? vs_dec : vs_cnt_reg);
	wire de_now = in_rows & (h_cnt_reg < hdisp_reg) & (row_cnt_reg < vertical_displayed_reg);
	wire [13:0] ma_now = ma_calc(rc_mode, row_base_reg, display_start_reg, row_cnt_reg,
		h_cnt_reg);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			h_cnt_reg <= 8'h00;
		else if (!run)
			h_cnt_reg <= 8'h00;
		else if (character_clock_rise)
			h_cnt_reg <= h_end ? 8'h00 : h_cnt_reg + 8'h01;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			vstate_reg <= crt_pkg::crt_v_rows;
			row_cnt_reg <= 7'h00;
			line_cnt_reg <= 5'h00;
			row_base_reg <= `CRT_RST_ADDR;
		end
		else if (!run)
		begin
			vstate_reg <= crt_pkg::crt_v_rows;
			row_cnt_reg <= 7'h00;
			line_cnt_reg <= 5'h00;
			row_base_reg <= display_start_reg;
		end
		else if (line_tick & frame_end)
		begin
			vstate_reg <= crt_pkg::crt_v_rows;
			row_cnt_reg <= 7'h00;
			line_cnt_reg <= 5'h00;
			row_base_reg <= display_start_reg;
		end
		else if (line_tick)
		begin
			case (vstate_reg)
				crt_pkg::crt_v_rows:
				begin
					line_cnt_reg <= last_line ? 5'h00 : line_cnt_reg + 5'h01;
					if (last_line & last_row)
						vstate_reg <= crt_pkg::crt_v_adjust;
					else if (last_line)
					begin
						row_cnt_reg <= row_cnt_reg + 7'h01;
						row_base_reg <= row_base_reg + {6'h00, hdisp_reg};
					end
				end
				crt_pkg::crt_v_adjust: line_cnt_reg <= line_cnt_reg + 5'h01;
				default: vstate_reg <= crt_pkg::crt_v_rows;
			endcase
		end
	end

	// video outputs, registered on the character tick so they line up with the address
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hs_cnt_reg <= 4'h0;
			vs_cnt_reg <= 5'h00;
			de_stage_reg <= 1'b0;
			hsync <= 1'b0;
			vsync <= 1'b0;
			display_enable <= 1'b0;
			refresh_address <= 14'h0000;
			raster_row_address <= 5'h00;
		end
		else if (!run)
		begin
			hs_cnt_reg <= 4'h0;
			vs_cnt_reg <= 5'h00;
			de_stage_reg <= 1'b0;
			hsync <= 1'b0;
			vsync <= 1'b0;
			display_enable <= 1'b0;
			refresh_address <= 14'h0000;
			raster_row_address <= 5'h00;
		end
		else if (character_clock_rise)
		begin
			hs_cnt_reg <= hs_next;
			vs_cnt_reg <= vs_next;
			hsync <= (hs_next != 4'h0);
			// the count loaded at a line end covers the line that follows, so vsync opens at line 0
			vsync <= (vs_cnt_reg != 5'h00);
			de_stage_reg <= de_now;
			display_enable <= mode_control_reg[`CRT_MODE_DE_DLY_BIT] ? de_stage_reg : de_now;
			refresh_address <= ma_now;
			raster_row_address <= line_cnt_reg;
		end
	end

	crt_cur_if cif();
	assign cif.tick = character_clock_rise;
	assign cif.run = run;
	assign cif.frame_tick = line_tick & frame_end;
	assign cif.ma = ma_now;
	assign cif.ra = line_cnt_reg;
	assign cif.cur_pos = cursor_position_reg;
	assign cif.cur_start = cursor_start_reg[4:0];
	assign cif.cur_end = cursor_end_reg;
	assign cif.cur_mode = crt_pkg::crt_cur_mode_t'(cursor_start_reg[`CRT_CMODE_MSB:`CRT_CMODE_LSB]);
	assign cif.delay = mode_control_reg[`CRT_MODE_CUR_DLY_BIT];
	assign cursor = cif.cursor;

	crt_cursor u_cursor
	(
		.clk(clk),
		.arst_n(arst_n),
		.cif(cif)
	);

	// read path; the dummy location leaves the bus undriven
	logic [7:0] rd_mux;
	wire [7:0] status = {upd_ready_reg, pen_full_reg, ~de_now & ~(in_rows
		& (row_cnt_reg < vertical_displayed_reg)), 5'h00};
	always_comb
	begin
		rd_mux = 8'h00;
		if (!rs_s)
			rd_mux = status;
		else
		begin
			case (ptr_reg)
				`CRT_IDX_CUR_HI: rd_mux = {2'b00, cursor_position_reg[13:8]};
				`CRT_IDX_CUR_LO: rd_mux = cursor_position_reg[7:0];
				`CRT_IDX_PEN_HI: rd_mux = {2'b00, light_pen_reg[13:8]};
				`CRT_IDX_PEN_LO: rd_mux = light_pen_reg[7:0];
				default: rd_mux = 8'h00;
			endcase
		end
	end
	wire oe_now = sync2_reg[11] & ~cs_n_s & rw_s & ~(rs_s & (ptr_reg == `CRT_IDX_DUMMY));
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			data_bus_out <= 8'h00;
			data_bus_oe <= 1'b0;
		end
		else
		begin
			data_bus_out <= rd_mux;
			data_bus_oe <= oe_now;
		end
	end
endmodule

// ### test/crt_raster_asserts.sv
// pin-level concurrent checks of the raster timing block
`timescale 1ns/1ns
module crt_raster_asserts
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// processor pins
	input wire logic bus_enable,
	input wire logic read_not_write,
	input wire logic chip_select_n,
	input wire logic data_bus_oe,
	// video pins
	input wire logic character_clock,
	input wire logic counter_reset_n,
	input wire logic hsync,
	input wire logic vsync,
	input wire logic display_enable,
	input wire logic cursor,
	input wire logic [13:0] refresh_address,
	input wire logic [4:0] raster_row_address
);
	logic [4:0] vs_lines_reg;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// counts line starts seen while vsync is high; no width may exceed sixteen lines
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			vs_lines_reg <= 5'h00;
		else if (!vsync)
			vs_lines_reg <= 5'h00;
		else if ($rose(hsync))
			vs_lines_reg <= vs_lines_reg + 5'h01;
	end
	a_reset_clears_video: assert property (
		!counter_reset_n [*4] |-> refresh_address == 14'h0000 && !hsync && !vsync
		&& !display_enable && !cursor && raster_row_address == 5'h00)
		else $error("video pins not cleared under counter reset");
	a_video_on_tick: assert property (
		$changed({refresh_address, hsync, vsync, cursor}) |-> $past(character_clock, 2)
		|| !$past(counter_reset_n, 2) || !$past(counter_reset_n, 3))
		else $error("video pins moved away from a character tick");
	a_row_steps: assert property (
		$changed(raster_row_address) && raster_row_address != 5'h00
		|-> raster_row_address == $past(raster_row_address) + 5'h01)
		else $error("raster row skipped a line");
	a_addr_counts: assert property (
		display_enable && $past(display_enable) && $changed(refresh_address)
		|-> refresh_address[7:0] == $past(refresh_address[7:0]) + 8'h01)
		else $error("refresh address did not advance by one");
	a_vsync_at_line0: assert property (
		$rose(vsync) |-> raster_row_address == 5'h00)
		else $error("vsync began away from the first line of a row");
	a_vsync_max_lines: assert property (
		vs_lines_reg <= 5'h10)
		else $error("vsync longer than sixteen lines");
	a_oe_needs_enable: assert property (
		!bus_enable [*4] |-> !data_bus_oe)
		else $error("data bus driven without enable");
	a_oe_needs_select: assert property (
		chip_select_n [*4] |-> !data_bus_oe)
		else $error("data bus driven while deselected");
	a_oe_write_quiet: assert property (
		!read_not_write [*4] |-> !data_bus_oe)
		else $error("data bus driven during a write");
endmodule
bind crt_raster_timing_regs crt_raster_asserts u_chk
(
	.clk(clk),
	.arst_n(arst_n),
	.bus_enable(bus_enable),
	.read_not_write(read_not_write),
	.chip_select_n(chip_select_n),
	.data_bus_oe(data_bus_oe),
	.character_clock(character_clock),
	.counter_reset_n(counter_reset_n),
	.hsync(hsync),
	.vsync(vsync),
	.display_enable(display_enable),
	.cursor(cursor),
	.refresh_address(refresh_address),
	.raster_row_address(raster_row_address)
);

// ### test/crt_video_partner.sv
// free running character clock and light pen source facing the raster block
`timescale 1ns/1ns
module crt_video_partner
(
	// clock
	input wire logic clk,
	// bench control
	input wire logic pen_req,
	// video pins
	input wire logic [13:0] refresh_address,
	output logic character_clock,
	output logic light_pen_strobe,
	output logic [13:0] pen_addr
);
	logic [2:0] phase = 3'h0;
	logic pen_arm = 1'b0;
	initial
	begin
		character_clock = 1'b0;
		light_pen_strobe = 1'b0;
		pen_addr = 14'h0000;
	end
	// four system clocks a phase keep the sync pipe inside one phase
	always @(negedge clk)
	begin
		phase <= phase + 3'h1;
		character_clock <= phase[2];
		// strobe rises just after a clock rise, so the next fall is the capture point
		if (pen_req && phase == 3'h5)
		begin
			light_pen_strobe <= 1'b1;
			pen_arm <= 1'b1;
		end
		if (phase == 3'h7)
			light_pen_strobe <= 1'b0;
		if (pen_arm && phase == 3'h0)
		begin
			pen_addr <= refresh_address;
			pen_arm <= 1'b0;
		end
	end
endmodule

// ### test/crt_raster_timing_regs_tb.sv
// self-checking bench for the raster timing block
`timescale 1ns/1ns
module crt_raster_timing_regs_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic bus_enable = 1'b0;
	logic read_not_write = 1'b1;
	logic chip_select_n = 1'b1;
	logic register_select_pin = 1'b0;
	logic [7:0] data_bus_in = 8'h00;
	logic counter_reset_n = 1'b1;
	logic pen_req = 1'b0;
	logic [7:0] data_bus_out;
	logic data_bus_oe, character_clock, light_pen_strobe, hsync, vsync, display_enable, cursor;
	logic [13:0] refresh_address;
	logic [13:0] pen_addr;
	logic [4:0] raster_row_address;
	int n_fail = 0;
	int tests_run = 0;
	always #50 clk = ~clk;
	crt_raster_timing_regs dut
	(
		.clk(clk),
		.arst_n(arst_n),
		.bus_enable(bus_enable),
		.read_not_write(read_not_write),
		.chip_select_n(chip_select_n),
		.register_select_pin(register_select_pin),
		.data_bus_in(data_bus_in),
		.data_bus_out(data_bus_out),
		.data_bus_oe(data_bus_oe),
		.character_clock(character_clock),
		.counter_reset_n(counter_reset_n),
		.light_pen_strobe(light_pen_strobe),
		.hsync(hsync),
		.vsync(vsync),
		.display_enable(display_enable),
		.cursor(cursor),
		.refresh_address(refresh_address),
		.raster_row_address(raster_row_address)
	);
	crt_video_partner u_far
	(
		.clk(clk),
		.pen_req(pen_req),
		.refresh_address(refresh_address),
		.character_clock(character_clock),
		.light_pen_strobe(light_pen_strobe),
		.pen_addr(pen_addr)
	);
	task summarize;
		if (n_fail == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one enable cycle; pins stay put for six clocks each side of the enable fall
	task bus(input logic rs, input logic rw, input logic [7:0] din, output logic [7:0] dout,
		output logic oe);
		@(negedge clk);
		chip_select_n = 1'b0;
		register_select_pin = rs;
		read_not_write = rw;
		data_bus_in = din;
		bus_enable = 1'b1;
		repeat (6) @(negedge clk);
		dout = data_bus_out;
		oe = data_bus_oe;
		bus_enable = 1'b0;
		repeat (6) @(negedge clk);
		chip_select_n = 1'b1;
		read_not_write = 1'b1;
	endtask
	task wr(input logic [4:0] idx, input logic [7:0] v);
		logic [7:0] d;
		logic o;
		bus(1'b0, 1'b0, {3'h0, idx}, d, o);
		bus(1'b1, 1'b0, v, d, o);
	endtask
	task rd(input logic [4:0] idx, output logic [7:0] v, output logic o);
		bus(1'b0, 1'b0, {3'h0, idx}, v, o);
		bus(1'b1, 1'b1, 8'h00, v, o);
	endtask
	task stat(output logic [7:0] v);
		logic o;
		bus(1'b0, 1'b1, 8'h00, v, o);
	endtask
	task wait_lvl(input int which, input logic lvl);
		for (int i = 0; i < 4000; i++)
		begin
			@(negedge clk);
			if ((which == 0 ? vsync : hsync) === lvl)
				return;
		end
		n_fail++;
		summarize();
	endtask
	task count_hi(input int which, output int n);
		wait_lvl(which, 1'b0);
		wait_lvl(which, 1'b1);
		for (n = 0; n < 3000 && (which == 0 ? vsync : hsync) === 1'b1; n++)
			@(negedge clk);
	endtask
	task t_after_reset;
		logic [7:0] v;
		logic o;
		stat(v);
		check(16'(v & 8'hc0), 16'h0000);
		rd(5'h0e, v, o);
		check(16'(v), 16'h0000);
		rd(5'h04, v, o);
		check(16'({o, v}), 16'h0100);
		rd(5'h1f, v, o);
		check(16'(o), 16'h0000);
	endtask
	task t_cursor_rw;
		logic [7:0] v;
		logic o;
		wr(5'h0e, 8'hea);
		wr(5'h0f, 8'h5c);
		rd(5'h0e, v, o);
		check(16'(v), 16'h002a);
		rd(5'h0f, v, o);
		check(16'(v), 16'h005c);
	endtask
	task t_dummy;
		logic [7:0] v;
		logic o;
		wr(5'h1f, 8'h00);
		stat(v);
		check(16'(v & 8'h80), 16'h0080);
		wr(5'h12, 8'h00);
		stat(v);
		check(16'(v & 8'h80), 16'h0000);
		rd(5'h1f, v, o);
		check(16'(o), 16'h0000);
		stat(v);
		check(16'(v & 8'h80), 16'h0080);
	endtask
	// 8 chars a line, 2 lines a row, 10 rows, vsync at row 2, start row 1 column 0x10
	task setup;
		logic [7:0] cfg [14];
		cfg = '{8'h07, 8'h04, 8'h05, 8'h02, 8'h09, 8'h00, 8'h01,
			8'h02, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h10};
		// counters held so the reprogramming cannot show up as a jump in the address count
		counter_reset_n = 1'b0;
		for (int i = 0; i < 14; i++)
			wr(5'(i), cfg[i]);
		counter_reset_n = 1'b1;
	endtask
	// cursor placed on the address seen at the first hsync of the vsync row;
	// writes land inside vsync, where no displayed address is being counted
	task t_address(input logic [7:0] mode, input logic [13:0] exp);
		wait_lvl(0, 1'b0);
		wait_lvl(0, 1'b1);
		wr(5'h08, mode);
		wr(5'h0e, {2'h0, exp[13:8]});
		wr(5'h0f, exp[7:0]);
		// a sixteen line vsync ends exactly at the frame start
		wait_lvl(0, 1'b0);
		check(16'(refresh_address), 16'h0110);
		check(16'(display_enable), 16'h0001);
		repeat (32) @(negedge clk);
		check(16'(display_enable), 16'h0000);
		wait_lvl(0, 1'b1);
		wait_lvl(1, 1'b1);
		check(16'(refresh_address), 16'(exp)); // refresh_address
		check(16'(raster_row_address), 16'h0000);
		check(16'(cursor), 16'(!mode[5]));
		repeat (8) @(negedge clk);
		check(16'(cursor), 16'(mode[5]));
	endtask
	task t_cursor_off;
		wr(5'h0a, 8'h20);
		wait_lvl(0, 1'b0);
		wait_lvl(0, 1'b1);
		wait_lvl(1, 1'b1);
		repeat (8) @(negedge clk);
		check(16'(cursor), 16'h0000);
		wr(5'h0a, 8'h00);
	endtask
	task t_vsync(input logic [7:0] widths, input int lines);
		int n;
		wr(5'h03, widths);
		count_hi(0, n);
		check(16'(n), 16'(lines * 64));
		count_hi(1, n);
		check(16'(n), 16'(int'(widths[3:0]) * 8));
	endtask
	task t_pen;
		logic [7:0] hi;
		logic [7:0] lo;
		logic o;
		pen_req = 1'b1;
		for (int i = 0; i < 20 && light_pen_strobe !== 1'b1; i++)
			@(negedge clk);
		pen_req = 1'b0;
		repeat (20) @(negedge clk);
		stat(lo);
		check(16'(lo & 8'h40), 16'h0040);
		rd(5'h10, hi, o);
		rd(5'h11, lo, o);
		check({hi, lo}, {2'h0, pen_addr});
		stat(lo);
		check(16'(lo & 8'h40), 16'h0000);
	endtask
	task t_counter_reset;
		logic [7:0] v;
		logic o;
		counter_reset_n = 1'b0;
		repeat (6) @(negedge clk);
		check({refresh_address, hsync, vsync}, 16'h0000);
		rd(5'h0f, v, o);
		check(16'(v), 16'h0015);
		counter_reset_n = 1'b1;
	endtask
	// three adjust lines stretch the gap between three line vsync pulses to 20 lines
	task t_adjust;
		int n;
		wr(5'h05, 8'h03);
		count_hi(0, n);
		for (n = 0; n < 3000 && vsync === 1'b0; n++)
			@(negedge clk);
		check(16'(n), 16'(20 * 64));
		wr(5'h05, 8'h00);
	endtask
	// frame count restarts at counter reset; blink 16 for frames 0-9, blink 32 after
	task t_blink;
		wr(5'h0a, 8'h40);
		for (int i = 0; i < 18; i++)
		begin
			if (i == 10)
				wr(5'h0a, 8'h60);
			wait_lvl(0, 1'b0);
			wait_lvl(0, 1'b1);
			wait_lvl(1, 1'b1);
			repeat (8) @(negedge clk);
			check(16'(cursor), 16'(i < 8 || (i >= 10 && i < 16)));
		end
	endtask
	initial
	begin
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_after_reset();
		t_cursor_rw();
		t_dummy();
		setup();
		t_address(8'h00, 14'h011d);
		t_address(8'h04, 14'h0315);
		t_address(8'h24, 14'h0315);
		t_cursor_off();
		t_vsync(8'h02, 16);
		t_vsync(8'h32, 3);
		t_adjust();
		t_pen();
		t_counter_reset();
		t_blink();
		summarize();
	end
endmodule
